// ### include/tap_port_pkg.sv
package tap_port_pkg;

    // ----------------------------------------------------------------
    // Register sizes
    // ----------------------------------------------------------------
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_WIDTH = 75;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 3'h0;
    localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 3'h1;
    localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 3'h4;
    localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 3'h7;

    // Pattern loaded into the instruction shifter at capture
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VAL = 3'h1;

    // ----------------------------------------------------------------
    // Identification code fields
    // ----------------------------------------------------------------
    localparam logic [3:0] ID_REVISION = 4'h0;
    localparam logic [4:0] ID_DEPTH = 5'h07;
    localparam logic [4:0] ID_WIDTH_CODE = 5'h04;
    localparam logic [5:0] ID_DEVICE = 6'h00;
    // Arbitrary maker code, not any real assignment
    localparam logic [10:0] ID_MAKER = 11'h2a5;
    localparam logic ID_PRESENT = 1'h1;

    // ----------------------------------------------------------------
    // Pin synchroniser reset levels
    // ----------------------------------------------------------------
    localparam logic TCK_RST_VAL = 1'h0;
    localparam logic PULLUP_RST_VAL = 1'h1;

    // ----------------------------------------------------------------
    // Port controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } tap_state_e;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID = 2'h1,
        SEL_BSR = 2'h2
    } dr_sel_e;

endpackage : tap_port_pkg

// ### src/pin_sync.sv
`timescale 1ns/10ps

// Two-flop synchroniser for signals from outside the sys_clk domain
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Only the second stage is visible to other logic
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : pin_sync

// ### src/sram_jtag_tap_port.sv
`timescale 1ns/10ps

// Function
// - Inputs sampled on test clock rise
// - Mode-select reads high when left open
// - Data-in reads high when left open
// - Data-in enters selected register MSB
// - Data-out from LSB, falling edge, shifting
// - One register selected by instruction
// - Five mode-select highs reach reset state
// - Port reset leaves memory operation alone
// - Power-up reset, data-out high impedance
// - Three-bit instruction register, shifts when selected
// - Reset loads identification instruction
// - Instruction capture loads binary 01
// - One-bit bypass register path
// - Bypass bit cleared on capture
// - Instruction takes effect at update
// - Hardwired 32-bit identification code, bit0 one
// - Code 000 samples, memory outputs high impedance
// - 75-bit boundary register captures and shifts
module sram_jtag_tap_port
    import tap_port_pkg::*;
#(
    parameter logic [ID_WIDTH-1:0] ID_CODE = {ID_REVISION, ID_DEPTH, ID_WIDTH_CODE,
        ID_DEVICE, ID_MAKER, ID_PRESENT}
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_WIDTH-1:0] io_ring,
    output logic tdo,
    output logic tdo_oe,
    output logic mem_out_hiz
);

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic [BSR_WIDTH-1:0] ring_s;
    logic tck_d_ff;
    logic tck_rise;
    logic tck_fall;

    pin_sync #(.WIDTH(1), .RST_VAL(TCK_RST_VAL)) u_sync_tck (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(tck),
        .sync_out(tck_s)
    );

    // pull-up resolved at the pin, reset level high
    pin_sync #(.WIDTH(1), .RST_VAL(PULLUP_RST_VAL)) u_sync_tms (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(tms),
        .sync_out(tms_s)
    );

    // pull-up resolved at the pin, reset level high
    pin_sync #(.WIDTH(1), .RST_VAL(PULLUP_RST_VAL)) u_sync_tdi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(tdi),
        .sync_out(tdi_s)
    );

    // Ring values may be in transition; a capture then holds either level
    pin_sync #(.WIDTH(BSR_WIDTH), .RST_VAL('0)) u_sync_ring (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(io_ring),
        .sync_out(ring_s)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tck_d_ff <= TCK_RST_VAL;
        end else begin
            tck_d_ff <= tck_s;
        end
    end

    // all port inputs act only on the rise
    assign tck_rise = tck_s & ~tck_d_ff;
    assign tck_fall = ~tck_s & tck_d_ff;

    // ----------------------------------------------------------------
    // Controller state machine
    // ----------------------------------------------------------------
    tap_state_e state_ff;
    tap_state_e nxt_state;

    // five highs from any state land in reset
    always_comb begin
        unique case (state_ff)
            ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: nxt_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: nxt_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // power-up reset puts the port in reset state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= ST_RESET;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------
    logic [IR_WIDTH-1:0] ir_shift_ff;
    logic [IR_WIDTH-1:0] instr_ff;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ir_shift_ff <= INSTR_IDCODE;
        end else if (tck_rise) begin
            // capture pattern 01 in low bits
            if (state_ff == ST_CAP_IR) begin
                ir_shift_ff <= IR_CAPTURE_VAL;
            end else if (state_ff == ST_SHIFT_IR) begin
                ir_shift_ff <= {tdi_s, ir_shift_ff[IR_WIDTH-1:1]};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            instr_ff <= INSTR_IDCODE;
        end else if (tck_rise) begin
            if (nxt_state == ST_RESET) begin
                instr_ff <= INSTR_IDCODE;
            end else if (state_ff == ST_UPD_IR) begin
                instr_ff <= ir_shift_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data register selection
    // ----------------------------------------------------------------
    dr_sel_e dr_sel;

    // instruction picks exactly one data register
    always_comb begin
        unique case (instr_ff)
            INSTR_EXTEST, INSTR_SAMPLE_Z, INSTR_SAMPLE: dr_sel = SEL_BSR;
            INSTR_IDCODE: dr_sel = SEL_ID;
            // reserved codes fall back to bypass
            default: dr_sel = SEL_BYPASS;
        endcase
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    logic bypass_ff;
    logic [ID_WIDTH-1:0] id_ff;
    logic [BSR_WIDTH-1:0] bsr_ff;
    logic dr_cap;
    logic dr_shift;

    assign dr_cap = tck_rise && (state_ff == ST_CAP_DR);
    assign dr_shift = tck_rise && (state_ff == ST_SHIFT_DR);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bypass_ff <= 1'h0;
        end else if (dr_sel == SEL_BYPASS) begin
            if (dr_cap) begin
                bypass_ff <= 1'h0;
            // data-in enters at the top bit
            end else if (dr_shift) begin
                bypass_ff <= tdi_s;
            end
        end
    end

    // hardwired code, bit 0 forced to one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            id_ff <= '0;
        end else if (dr_sel == SEL_ID) begin
            if (dr_cap) begin
                id_ff <= {ID_CODE[ID_WIDTH-1:1], ID_PRESENT};
            end else if (dr_shift) begin
                id_ff <= {tdi_s, id_ff[ID_WIDTH-1:1]};
            end
        end
    end

    // boundary register captures ring, then shifts
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bsr_ff <= '0;
        end else if (dr_sel == SEL_BSR) begin
            if (dr_cap) begin
                bsr_ff <= ring_s;
            end else if (dr_shift) begin
                bsr_ff <= {tdi_s, bsr_ff[BSR_WIDTH-1:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial output and memory output control
    // ----------------------------------------------------------------
    logic dr_lsb;
    logic tdo_ff;
    logic tdo_oe_ff;
    logic mem_out_hiz_ff;

    always_comb begin
        unique case (dr_sel)
            SEL_ID: dr_lsb = id_ff[0];
            SEL_BSR: dr_lsb = bsr_ff[0];
            default: dr_lsb = bypass_ff;
        endcase
    end

    // LSB driven on the fall, only while shifting
    // held off from power-up until a shift state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tdo_ff <= 1'h0;
            tdo_oe_ff <= 1'h0;
        end else if (tck_fall) begin
            tdo_ff <= (state_ff == ST_SHIFT_IR) ? ir_shift_ff[0] : dr_lsb;
            tdo_oe_ff <= (state_ff == ST_SHIFT_IR) || (state_ff == ST_SHIFT_DR);
        end
    end

    // code 000 and sample-z float the memory outputs
    // nothing else here reaches the memory datapath
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_out_hiz_ff <= 1'h0;
        end else begin
            mem_out_hiz_ff <= (instr_ff == INSTR_EXTEST) || (instr_ff == INSTR_SAMPLE_Z);
        end
    end

    assign tdo = tdo_ff;
    assign tdo_oe = tdo_oe_ff;
    assign mem_out_hiz = mem_out_hiz_ff;

endmodule : sram_jtag_tap_port

// ### test/tap_port_assertions.sv
`timescale 1ns/10ps
module tap_port_assertions
    import tap_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_WIDTH-1:0] io_ring,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic mem_out_hiz
);
    logic tck_ff;
    logic [3:0] fall_age_ff;
    logic [3:0] rise_age_ff;
    logic [2:0] tms_cnt_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----
    // Test clock edge ages, checker sees tck two flops early
    // ----
    always_ff @(posedge sys_clk) begin
        tck_ff <= rst_n & tck;
    end
    always_ff @(posedge sys_clk) begin
        fall_age_ff <= (tck_ff & !tck) ? 4'h0 : fall_age_ff + {3'h0, fall_age_ff != 4'hf};
        rise_age_ff <= (!tck_ff & tck) ? 4'h0 : rise_age_ff + {3'h0, rise_age_ff != 4'hf};
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tms_cnt_ff <= 3'h0;
        end else if (!tck_ff & tck) begin
            tms_cnt_ff <= !tms ? 3'h0 : tms_cnt_ff + {2'h0, tms_cnt_ff != 3'h5};
        end
    end
    property p_tdo_hold;
        tck && $past(tck) && $past(tck, 2) |-> $stable(tdo) && $stable(tdo_oe);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold)
        else $error("tdo moved while tck high");
    property p_out_fall;
        $changed(tdo) || $changed(tdo_oe) |-> fall_age_ff inside {[1:4]};
    endproperty
    a_out_fall: assert property (p_out_fall)
        else $error("tdo change not tied to tck fall");
    property p_oe_stands;
        $rose(tdo_oe) |-> tdo_oe [*6];
    endproperty
    a_oe_stands: assert property (p_oe_stands)
        else $error("tdo_oe dropped early");
    property p_rst_quiet;
        $rose(rst_n) |-> !tdo && !tdo_oe && !mem_out_hiz;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active after reset");
    property p_hiz_rise;
        $changed(mem_out_hiz) |-> rise_age_ff inside {[2:6]};
    endproperty
    a_hiz_rise: assert property (p_hiz_rise)
        else $error("hiz change not tied to tck rise");
    property p_tms_rst;
        tms_cnt_ff == 3'h5 |-> ##[0:4] !mem_out_hiz;
    endproperty
    a_tms_rst: assert property (p_tms_rst)
        else $error("five tms highs did not reset");
    property p_mem_keep;
        tms_cnt_ff == 3'h5 |-> !$rose(mem_out_hiz);
    endproperty
    a_mem_keep: assert property (p_mem_keep)
        else $error("port reset disturbed memory outputs");
    property p_oe_idle;
        tms_cnt_ff >= 3'h2 |-> !tdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("tdo_oe high outside shift");
endmodule : tap_port_assertions

bind sram_jtag_tap_port tap_port_assertions chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe),
    .mem_out_hiz(mem_out_hiz));

// ### test/jtag_ctl_model.sv
`timescale 1ns/10ps
module jtag_ctl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #160 tck = 1'h1;
        #160 q = tdo;
        tck = 1'h0;
    endtask : step
    task automatic scan(input logic ir, input int n, input logic [79:0] din,
        output logic [79:0] dout);
        logic q;
        dout = '0;
        step(1'h0, 1'h1, q);
        step(1'h1, 1'h1, q);
        if (ir) step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
        step(1'h0, 1'h1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
    endtask : scan
    task automatic tlr();
        logic q;
        repeat (5) step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
    endtask : tlr
endmodule : jtag_ctl_model

// ### test/sram_jtag_tap_port_test.sv
`timescale 1ns/10ps
module sram_jtag_tap_port_test;
    import tap_port_pkg::*;
    // Arbitrary code, bit 0 set
    localparam logic [31:0] TB_ID = 32'h5a3ce6b3;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [BSR_WIDTH-1:0] io_ring = '0;
    logic tck, tms, tdi, tdo, tdo_oe, mem_out_hiz;
    wire tdo_pin = tdo_oe ? tdo : 1'bz;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    sram_jtag_tap_port #(.ID_CODE(TB_ID)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe),
        .mem_out_hiz(mem_out_hiz));
    jtag_ctl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
    // ----
    // Checking
    // ----
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [79:0] got, input logic [79:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // Path length and capture value follow the instruction
    function automatic logic [79:0] exp_dr(input logic [2:0] code, input logic [79:0] din,
        input logic [74:0] ring);
        case (code)
            3'h1: exp_dr = {din[47:0], TB_ID};
            3'h0, 3'h2, 3'h4: exp_dr = {din[4:0], ring};
            default: exp_dr = {din[78:0], 1'h0};
        endcase
    endfunction : exp_dr
    task automatic id_read();
        logic [79:0] din;
        logic [79:0] dout;
        din = 80'({$urandom(), $urandom(), $urandom()});
        ctl_u.scan(1'h0, 80, din, dout);
        check(dout, exp_dr(INSTR_IDCODE, din, io_ring), "id");
    endtask : id_read
    task automatic reset_case(input bit by_pin);
        logic [79:0] dout;
        logic q;
        ctl_u.scan(1'h1, 3, 80'h0, dout);
        repeat (4) @(posedge sys_clk);
        #1;
        check(80'(mem_out_hiz), 80'h1, "hiz set");
        if (by_pin) begin
            rst_n = 1'h0;
            repeat (3) @(posedge sys_clk);
            #1 rst_n = 1'h1;
        end else begin
            // Park in data shift so that all five highs are needed
            ctl_u.step(1'h1, 1'h1, q);
            ctl_u.step(1'h0, 1'h1, q);
            ctl_u.step(1'h0, 1'h1, q);
            ctl_u.tlr();
        end
        repeat (6) @(posedge sys_clk);
        #1;
        check(80'(mem_out_hiz), 80'h0, "hiz clear");
        id_read();
        $display("reset case %0d done", by_pin);
    endtask : reset_case
    // ----
    // Sequence
    // ----
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        logic [79:0] din;
        logic [79:0] dout;
        void'($urandom(32'h277b));
        repeat (20) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        repeat (6) @(posedge sys_clk);
        #1;
        id_read();
        $display("id read done");
        for (int c = 0; c < 8; c++) begin
            din = 80'({$urandom(), $urandom(), $urandom()});
            @(posedge sys_clk);
            #1 io_ring = 75'({$urandom(), $urandom(), $urandom()});
            ctl_u.scan(1'h1, 3, 80'(c), dout);
            check(dout, 80'h1, "ir capture");
            repeat (4) @(posedge sys_clk);
            #1;
            check(80'(mem_out_hiz), 80'(c == 0 || c == 2), "hiz");
            ctl_u.scan(1'h0, 80, din, dout);
            check(dout, exp_dr(3'(c), din, io_ring), "dr");
            $display("code %0d done", c);
        end
        reset_case(1'b0);
        reset_case(1'b1);
        stop_test();
    end
endmodule : sram_jtag_tap_port_test
